// [src/sbw_cfg.svh]
`ifndef SBW_CFG_SVH
`define SBW_CFG_SVH

// Core clock in kHz (20 MHz)
`define SBW_CLK_KHZ 20000
// Timing figures in their own units
`define SBW_CFG_TIMEOUT_MS 350
`define SBW_IRQ_PULSE_US 10
`define SBW_DEGLITCH_US 40
`define SBW_RESET_PULSE_MS 1
`define SBW_IRQ_TO_SPI_US 20
// Watchdog periods per two-bit period field
`define SBW_WD_P0_MS 10
`define SBW_WD_P1_MS 45
`define SBW_WD_P2_MS 100
`define SBW_WD_P3_MS 350
// Derived cycle counts
`define SBW_US_CYC(us) ((us) * `SBW_CLK_KHZ / 1000)
`define SBW_MS_CYC(ms) ((ms) * `SBW_CLK_KHZ)
// Reset values
`define SBW_RST_WINDOW 1'b1
`define SBW_RST_PERIOD 2'b00
`define SBW_RST_SAFE 1'b0

`endif

// [src/sbw_pkg.sv]
package sbw_pkg;
  // Device operating modes
  typedef enum logic [2:0] {
    SBW_RESET,
    SBW_NREQ,
    SBW_NORMAL,
    SBW_STANDBY,
    SBW_STOP,
    SBW_SLEEP
  } sbw_mode_t;
  // Origin of the current configuration phase
  typedef enum logic [1:0] {
    SBW_FROM_POWER,
    SBW_FROM_STOP,
    SBW_FROM_SLEEP
  } sbw_origin_t;
endpackage

// [src/sbw_supervisor.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sbw_cfg.svh"

// Summary of operation
// - Unconfigured 350 ms: reset, then retry forever
// - Unconfigured after sleep wake: back to sleep
// - Device wake in stop: config plus pulse
// - Chip-select rising in stop wakes device
// - Overcurrent in stop wakes, no flag set
// - Wake pulse 10 us long on entering config from stop
// - Record CAN or input-change cause of a stop wake
// - Ignore SPI until delay after pulse
// - Stop watchdog expiry asserts reset, reconfigures
// - Stop taken at chip-select rising edge
// - Overcurrent wake blanked 40 us after stop
// - Window or timeout watchdog in normal, standby
// - Two-bit period field, 10 to 350 ms
// - Closed-window clear triggers reset in mode 1, fault only in safe mode
// - Timing register access clears watchdog
// - Supply low holds reset low
// - Power-on: reset low until supply good
// - Mode 1 timeout: reset pulse fixed time
// - Timeout drives fault low until register access
// - Safe mode timeout in normal, standby: no reset, fault only
// - Safe bit picks mode, default mode 1
// - Config write ends timer, enters requested mode
// - Reset mode: timer, then configuration mode
module sbw_supervisor
  import sbw_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Chip select pin, active low, asynchronous
  input wire logic spi_cs_n,
  // Decoded SPI events from the frame logic, core clock domain
  input wire logic wd_cfg_write,
  input wire logic wd_cfg_standby,
  input wire logic window_select_bit,
  input wire logic period_select_bit0,
  input wire logic period_select_bit1,
  input wire logic watchdog_timing_reg_access,
  input wire logic stop_cmd,
  input wire logic sleep_cmd,
  input wire logic safe_mode_bit,
  input wire logic mode_ctrl_write,
  input wire logic wd_stop_enable,
  // Analog and wake sources, asynchronous
  input wire logic supply_good,
  input wire logic can_wake,
  input wire logic input_change_wake,
  input wire logic stop_current_wake_threshold,
  input wire logic forced_wake,
  input wire logic sleep_wake,
  // Wake status clears
  input wire logic wake_flags_clear,
  // Outputs
  output logic reset_out_n,
  output logic watchdog_fault_output_n,
  output logic irq_out_n,
  output logic spi_accept,
  output logic can_wake_flag,
  output logic input_change_flags,
  output logic safe_mode,
  output logic window_mode,
  output logic [1:0] wd_period,
  output sbw_mode_t mode
);

  // Cycle counts derived from the timing figures
  localparam int CFG_CYC = `SBW_MS_CYC(`SBW_CFG_TIMEOUT_MS);
  localparam int IRQ_CYC = `SBW_US_CYC(`SBW_IRQ_PULSE_US);
  localparam int DGL_CYC = `SBW_US_CYC(`SBW_DEGLITCH_US);
  localparam int RST_CYC = `SBW_MS_CYC(`SBW_RESET_PULSE_MS);
  localparam int SPI_CYC = `SBW_US_CYC(`SBW_IRQ_TO_SPI_US);
  localparam int CW = 24;

  // Watchdog period in cycles for a period field
  function automatic logic [CW-1:0] period_cyc(input logic [1:0] sel);
    case (sel)
      2'b00: period_cyc = CW'(`SBW_MS_CYC(`SBW_WD_P0_MS));
      2'b01: period_cyc = CW'(`SBW_MS_CYC(`SBW_WD_P1_MS));
      2'b10: period_cyc = CW'(`SBW_MS_CYC(`SBW_WD_P2_MS));
      default: period_cyc = CW'(`SBW_MS_CYC(`SBW_WD_P3_MS));
    endcase
  endfunction

  // Two-flop synchronisers for all asynchronous inputs
  localparam int NS = 7;
  // Chip select idles high, so its chain starts high to avoid a false edge
  localparam logic [NS-1:0] SYNC_RST = 7'h40;
  logic [NS-1:0] async_in;
  logic [NS-1:0] sync1_reg;
  logic [NS-1:0] sync2_reg;
  assign async_in = {spi_cs_n, supply_good, can_wake, input_change_wake,
                     stop_current_wake_threshold, forced_wake, sleep_wake};
  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++) begin : g_sync
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          sync1_reg[gi] <= SYNC_RST[gi];
          sync2_reg[gi] <= SYNC_RST[gi];
        end else begin
          sync1_reg[gi] <= async_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  logic cs_s, vgood_s, canw_s, inw_s, ocw_s, fw_s, slw_s;
  assign {cs_s, vgood_s, canw_s, inw_s, ocw_s, fw_s, slw_s} = sync2_reg;

  // Previous chip-select level for edge detection
  logic cs_prev_reg;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cs_prev_reg <= 1'b1;
    end else begin
      cs_prev_reg <= cs_s;
    end
  end
  logic cs_rise;
  assign cs_rise = cs_s & ~cs_prev_reg;

  // State registers
  sbw_mode_t mode_reg;
  sbw_origin_t origin_reg;
  logic [CW-1:0] tmr_reg;      // Mode timer: config, reset, deglitch
  logic [CW-1:0] wd_cnt_reg;   // Watchdog period counter
  logic stop_pend_reg;         // Stop command waiting for frame end
  logic fault_reg;             // Watchdog fault latched
  logic [9:0] irq_cnt_reg;     // Interrupt pulse length
  logic [9:0] spi_cnt_reg;     // Post-pulse SPI blanking
  logic irq_arm_reg;           // Pulse owed after stop wake
  logic safe_reg;
  logic window_reg;
  logic [1:0] period_reg;

  // Derived watchdog events
  logic [CW-1:0] per_now;
  logic wd_active, wd_expire, closed, wd_clear_ok, wd_clear_bad;
  logic stop_wd, stop_wake, oc_armed, accept;
  assign per_now = period_cyc(period_reg);
  // Commands are refused from the wake edge on, not only once the pulse starts
  assign accept = (spi_cnt_reg == '0) && !irq_arm_reg;
  assign wd_active = (mode_reg == SBW_NORMAL) || (mode_reg == SBW_STANDBY);
  assign stop_wd = (mode_reg == SBW_STOP) && wd_stop_enable;
  assign wd_expire = (wd_active || stop_wd) && (wd_cnt_reg >= per_now - 1'b1);
  // Closed part is the first half of the period
  assign closed = window_reg && (wd_cnt_reg < (per_now >> 1));
  assign wd_clear_ok = wd_active && accept && watchdog_timing_reg_access && !closed;
  assign wd_clear_bad = wd_active && accept && watchdog_timing_reg_access && closed;
  // Overcurrent wake only after the deglitch time has run out
  assign oc_armed = (tmr_reg >= CW'(DGL_CYC));
  assign stop_wake = (mode_reg == SBW_STOP) &&
                     (canw_s || inw_s || fw_s || cs_rise || (ocw_s && oc_armed));

  // Watchdog configuration and safe bit; mode 1 after reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      safe_reg <= `SBW_RST_SAFE;
      window_reg <= `SBW_RST_WINDOW;
      period_reg <= `SBW_RST_PERIOD;
    end else if (accept) begin
      if (mode_ctrl_write) begin
        safe_reg <= safe_mode_bit;
      end
      if (wd_cfg_write) begin
        window_reg <= window_select_bit;
        period_reg <= {period_select_bit1, period_select_bit0};
      end
    end
  end

  // Main mode sequencer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_reg <= SBW_RESET;
      origin_reg <= SBW_FROM_POWER;
      tmr_reg <= '0;
      stop_pend_reg <= 1'b0;
      irq_arm_reg <= 1'b0;
    end else begin
      irq_arm_reg <= 1'b0;
      case (mode_reg)
        SBW_RESET: begin
          // A stop request never outlives a reset
          stop_pend_reg <= 1'b0;
          // Reset timer only runs once the supply is good
          if (!vgood_s) begin
            tmr_reg <= '0;
          end else if (tmr_reg >= CW'(RST_CYC - 1)) begin
            mode_reg <= SBW_NREQ;
            tmr_reg <= '0;
          end else begin
            tmr_reg <= tmr_reg + 1'b1;
          end
        end
        SBW_NREQ: begin
          if (accept && wd_cfg_write) begin
            mode_reg <= wd_cfg_standby ? SBW_STANDBY : SBW_NORMAL;
            tmr_reg <= '0;
          end else if (tmr_reg >= CW'(CFG_CYC - 1)) begin
            tmr_reg <= '0;
            if (origin_reg == SBW_FROM_SLEEP) begin
              mode_reg <= SBW_SLEEP;
            end else begin
              mode_reg <= SBW_RESET;
              origin_reg <= SBW_FROM_POWER;
            end
          end else begin
            tmr_reg <= tmr_reg + 1'b1;
          end
        end
        SBW_NORMAL, SBW_STANDBY: begin
          if (accept && stop_cmd) begin
            stop_pend_reg <= 1'b1;
          end
          if (wd_expire && !safe_reg) begin
            mode_reg <= SBW_RESET;
            tmr_reg <= '0;
          end else if (wd_clear_bad && !safe_reg) begin
            mode_reg <= SBW_RESET;
            tmr_reg <= '0;
          end else if (stop_pend_reg && cs_rise) begin
            mode_reg <= SBW_STOP;
            stop_pend_reg <= 1'b0;
            tmr_reg <= '0;
          end else if (accept && sleep_cmd) begin
            mode_reg <= SBW_SLEEP;
          end
        end
        SBW_STOP: begin
          if (!oc_armed) begin
            tmr_reg <= tmr_reg + 1'b1;
          end
          if (stop_wd && wd_expire) begin
            mode_reg <= SBW_RESET;
            origin_reg <= SBW_FROM_POWER;
            tmr_reg <= '0;
          end else if (stop_wake) begin
            mode_reg <= SBW_NREQ;
            origin_reg <= SBW_FROM_STOP;
            tmr_reg <= '0;
            irq_arm_reg <= 1'b1;
          end
        end
        default: begin
          // Sleep: wake goes through reset first
          if (slw_s || canw_s || inw_s || fw_s) begin
            mode_reg <= SBW_RESET;
            origin_reg <= SBW_FROM_SLEEP;
            tmr_reg <= '0;
          end
        end
      endcase
      // Supply drop forces reset from any powered mode
      if (!vgood_s && mode_reg != SBW_SLEEP) begin
        mode_reg <= SBW_RESET;
        tmr_reg <= '0;
      end
    end
  end

  // Watchdog period counter
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wd_cnt_reg <= '0;
    end else if (!(wd_active || stop_wd) || wd_expire || wd_clear_ok ||
                 (accept && wd_cfg_write)) begin
      wd_cnt_reg <= '0;
    end else begin
      wd_cnt_reg <= wd_cnt_reg + 1'b1;
    end
  end

  // Watchdog fault latch; set wins over the clearing access
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fault_reg <= 1'b0;
    end else if (wd_expire || wd_clear_bad) begin
      fault_reg <= 1'b1;
    end else if (accept && (watchdog_timing_reg_access || wd_cfg_write)) begin
      fault_reg <= 1'b0;
    end
  end

  // Wake interrupt pulse, then SPI blanking window
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_cnt_reg <= '0;
      spi_cnt_reg <= '0;
    end else if (irq_arm_reg) begin
      irq_cnt_reg <= 10'(IRQ_CYC);
      spi_cnt_reg <= 10'(IRQ_CYC + SPI_CYC);
    end else begin
      if (irq_cnt_reg != '0) begin
        irq_cnt_reg <= irq_cnt_reg - 1'b1;
      end
      if (spi_cnt_reg != '0) begin
        spi_cnt_reg <= spi_cnt_reg - 1'b1;
      end
    end
  end

  // Wake cause flags; a new cause wins over a clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      can_wake_flag <= 1'b0;
      input_change_flags <= 1'b0;
    end else begin
      if (stop_wake && canw_s) begin
        can_wake_flag <= 1'b1;
      end else if (wake_flags_clear) begin
        can_wake_flag <= 1'b0;
      end
      if (stop_wake && inw_s) begin
        input_change_flags <= 1'b1;
      end else if (wake_flags_clear) begin
        input_change_flags <= 1'b0;
      end
    end
  end

  // Registered pin outputs; the host relies on the interrupt to resume
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reset_out_n <= 1'b0;
      watchdog_fault_output_n <= 1'b0;
      irq_out_n <= 1'b1;
    end else begin
      reset_out_n <= !(mode_reg == SBW_RESET || mode_reg == SBW_SLEEP);
      watchdog_fault_output_n <= !fault_reg;
      irq_out_n <= (irq_cnt_reg == '0);
    end
  end

  assign spi_accept = accept;
  assign safe_mode = safe_reg;
  assign window_mode = window_reg;
  assign wd_period = period_reg;
  assign mode = mode_reg;

endmodule
`default_nettype wire

// [testbench/sbw_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Host side of the chip-select link: one short frame per request
module sbw_host_model (
  // Frame request from the bench
  input wire logic go,
  // Chip select, active low
  output logic spi_cs_n
);
  logic link_clk; // Stands still between frames
  initial begin
    spi_cs_n = 1'b1;
    link_clk = 1'b0;
  end
  // Select, clock four bits at 400 ns, deselect; the rising edge is the trigger
  always @(posedge go) begin
    #10; // Keep chip select edges off the core clock edge
    spi_cs_n = 1'b0;
    repeat (8) #200 link_clk = ~link_clk;
    spi_cs_n = 1'b1;
  end
endmodule
`default_nettype wire

// [testbench/sbw_sup_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
// Port-level checker for the supervisor, one clock domain
module sbw_sup_monitor
  import sbw_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Decoded command inputs and the supply level
  input wire logic wd_cfg_write,
  input wire logic wd_cfg_standby,
  input wire logic window_select_bit,
  input wire logic period_select_bit0,
  input wire logic period_select_bit1,
  input wire logic watchdog_timing_reg_access,
  input wire logic supply_good,
  // Design outputs
  input wire logic reset_out_n,
  input wire logic irq_out_n,
  input wire logic spi_accept,
  input wire logic safe_mode,
  input wire logic window_mode,
  input wire logic [1:0] wd_period,
  input wire sbw_mode_t mode
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Configuration write taken while waiting for setup
  sequence s_cfg;
    mode == SBW_NREQ && wd_cfg_write && spi_accept;
  endsequence
  // Clear that lands right after setup, deep in the closed half
  sequence s_early_clr;
    s_cfg ##[1:4] watchdog_timing_reg_access && spi_accept && window_mode && !safe_mode;
  endsequence
  property p_cfg_mode;
    s_cfg |=> mode == ($past(wd_cfg_standby) ? SBW_STANDBY : SBW_NORMAL);
  endproperty
  property p_cfg_fields;
    s_cfg |=> wd_period == $past({period_select_bit1, period_select_bit0}) && window_mode == $past(window_select_bit);
  endproperty
  property p_closed_clr;
    s_early_clr |=> mode == SBW_RESET;
  endproperty
  property p_rst_hold;
    mode == SBW_RESET ##1 mode == SBW_RESET |-> !reset_out_n;
  endproperty
  // Sync plus mode plus pin stage fit in six cycles
  property p_supply;
    !supply_good [*6] |-> !reset_out_n;
  endproperty
  property p_irq_len;
    $fell(irq_out_n) |-> !irq_out_n [*8];
  endproperty
  property p_irq_nreq;
    $fell(irq_out_n) |-> mode == SBW_NREQ;
  endproperty
  property p_quiet;
    $rose(irq_out_n) |-> !spi_accept;
  endproperty
  a_cfg_mode: assert property (p_cfg_mode) else $error("setup write gave wrong mode");
  a_cfg_fields: assert property (p_cfg_fields) else $error("setup fields not taken");
  a_closed_clr: assert property (p_closed_clr) else $error("closed clear gave no reset");
  a_rst_hold: assert property (p_rst_hold) else $error("reset pin high in reset mode");
  a_supply: assert property (p_supply) else $error("reset pin high on low supply");
  a_irq_len: assert property (p_irq_len) else $error("wake pulse too short");
  a_irq_nreq: assert property (p_irq_nreq) else $error("wake pulse outside setup mode");
  a_quiet: assert property (p_quiet) else $error("commands taken right after pulse");
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sbw_cfg.svh"
module tb_top;
  import sbw_pkg::*;
  // Clock, reset and design inputs
  logic core_clk = 1'b0, rst = 1'b1;
  logic wd_cfg_write, wd_cfg_standby, window_select_bit, period_select_bit0, period_select_bit1;
  logic watchdog_timing_reg_access, stop_cmd, sleep_cmd, safe_mode_bit, mode_ctrl_write, wd_stop_enable;
  logic supply_good, can_wake, input_change_wake, stop_current_wake_threshold, forced_wake, sleep_wake;
  logic wake_flags_clear, go;
  wire logic spi_cs_n;
  // Design outputs
  logic reset_out_n, watchdog_fault_output_n, irq_out_n, spi_accept, can_wake_flag, input_change_flags;
  logic safe_mode, window_mode;
  logic [1:0] wd_period;
  sbw_mode_t mode;
  // Rows: wake source, standby, window, period
  logic [5:0] rows [4] = '{6'h00, 6'h1D, 6'h22, 6'h3B};
  logic [1:0] src;
  int lo, bad_count = 0, total_checks = 0;
  // Free-running core clock
  always #25 core_clk = ~core_clk;
  sbw_supervisor i_sbw_supervisor (.core_clk, .rst, .spi_cs_n, .wd_cfg_write, .wd_cfg_standby,
    .window_select_bit, .period_select_bit0, .period_select_bit1, .watchdog_timing_reg_access,
    .stop_cmd, .sleep_cmd, .safe_mode_bit, .mode_ctrl_write, .wd_stop_enable, .supply_good, .can_wake,
    .input_change_wake, .stop_current_wake_threshold, .forced_wake, .sleep_wake, .wake_flags_clear,
    .reset_out_n, .watchdog_fault_output_n, .irq_out_n, .spi_accept, .can_wake_flag,
    .input_change_flags, .safe_mode, .window_mode, .wd_period, .mode);
  sbw_host_model i_sbw_host_model (.go, .spi_cs_n);
  // Compare and count
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Bounded wait for a mode, ends off the edge
  task automatic wmode(input sbw_mode_t m, input int n);
    for (int i = 0; i < n && mode !== m; i++) @(negedge core_clk);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Watchdog setup write: standby, window, period
  task automatic cfg(input logic [3:0] f);
    @(posedge core_clk);
    {wd_cfg_standby, window_select_bit, period_select_bit1, period_select_bit0} <= f;
    wd_cfg_write <= 1'b1;
    @(posedge core_clk);
    wd_cfg_write <= 1'b0;
  endtask
  task automatic end_sim;
    $display("Checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard, well past the expected run
  initial begin
    #5_000_000;
    bad_count++;
    end_sim();
  end
  initial begin
    {wd_cfg_write, wd_cfg_standby, window_select_bit, period_select_bit0, period_select_bit1} = '0;
    {watchdog_timing_reg_access, stop_cmd, sleep_cmd, safe_mode_bit, mode_ctrl_write, wd_stop_enable} = '0;
    {can_wake, input_change_wake, stop_current_wake_threshold, forced_wake, sleep_wake} = '0;
    {wake_flags_clear, go} = '0;
    supply_good = 1'b1;
    tick(12);
    rst <= 1'b0;
    wmode(SBW_NREQ, 21000);
    chk("mode", SBW_NREQ, mode);
    @(negedge core_clk);
    chk("reset", 1, reset_out_n);
    chk("defaults", 4, {safe_mode, window_mode, wd_period});
    // Each row: setup, stop on frame end, wake by one source
    foreach (rows[r]) begin
      src = rows[r][5:4];
      @(posedge core_clk) wake_flags_clear <= 1'b1;
      @(posedge core_clk) wake_flags_clear <= 1'b0;
      cfg(rows[r][3:0]);
      wmode(rows[r][3] ? SBW_STANDBY : SBW_NORMAL, 4);
      chk("mode", rows[r][3] ? SBW_STANDBY : SBW_NORMAL, mode);
      chk("fields", rows[r][2:0], {window_mode, wd_period});
      @(posedge core_clk) stop_cmd <= 1'b1;
      @(posedge core_clk) stop_cmd <= 1'b0;
      go <= 1'b1;
      chk("early stop", 0, mode == SBW_STOP);
      wmode(SBW_STOP, 60);
      chk("stop", SBW_STOP, mode);
      @(posedge core_clk) go <= 1'b0;
      tick(900); // Past the overcurrent blanking
      can_wake <= src == 0;
      input_change_wake <= src == 1;
      stop_current_wake_threshold <= src == 2;
      go <= src == 3;
      wmode(SBW_NREQ, 60);
      chk("wake", SBW_NREQ, mode);
      lo = 0;
      repeat (260) begin
        @(negedge core_clk);
        lo += (irq_out_n === 1'b0);
      end
      chk("irq", `SBW_US_CYC(`SBW_IRQ_PULSE_US), lo);
      chk("flags", {src == 0, src == 1}, {can_wake_flag, input_change_flags});
      chk("quiet", 0, spi_accept);
      @(posedge core_clk) {can_wake, input_change_wake, stop_current_wake_threshold, go} <= '0;
      tick(450);
      chk("accept", 1, spi_accept);
    end
    // Clear in the closed half of a 10 ms window
    cfg(4'h4);
    tick(2);
    @(posedge core_clk) watchdog_timing_reg_access <= 1'b1;
    @(posedge core_clk) watchdog_timing_reg_access <= 1'b0;
    wmode(SBW_RESET, 5);
    chk("closed", SBW_RESET, mode);
    tick(3);
    chk("pins", 0, {reset_out_n, watchdog_fault_output_n});
    wmode(SBW_NREQ, 21000);
    chk("fault held", 0, watchdog_fault_output_n);
    cfg(4'h4);
    tick(3);
    chk("fault clr", 1, watchdog_fault_output_n);
    // Safe bit, then a supply drop
    @(posedge core_clk) {safe_mode_bit, mode_ctrl_write} <= 2'h3;
    @(posedge core_clk) mode_ctrl_write <= 1'b0;
    tick(2);
    chk("safe", 1, safe_mode);
    supply_good <= 1'b0;
    tick(8);
    chk("supply", 0, reset_out_n);
    supply_good <= 1'b1;
    wmode(SBW_NREQ, 21000);
    @(negedge core_clk);
    chk("back", 1, reset_out_n);
    // Overcurrent inside the stop blanking time, then past it
    cfg(4'h0);
    @(posedge core_clk) stop_cmd <= 1'b1;
    @(posedge core_clk) stop_cmd <= 1'b0;
    go <= 1'b1;
    wmode(SBW_STOP, 60);
    @(posedge core_clk) {go, stop_current_wake_threshold} <= 2'h1;
    tick(400);
    chk("blank", SBW_STOP, mode);
    wmode(SBW_NREQ, 500);
    chk("late wake", SBW_NREQ, mode);
    @(posedge core_clk) stop_current_wake_threshold <= 1'b0;
    tick(700);
    // Sleep, then a wake that passes through reset
    cfg(4'h0);
    @(posedge core_clk) sleep_cmd <= 1'b1;
    @(posedge core_clk) sleep_cmd <= 1'b0;
    tick(3);
    chk("sleep", SBW_SLEEP, mode);
    chk("sleep pin", 0, reset_out_n);
    @(posedge core_clk) sleep_wake <= 1'b1;
    wmode(SBW_RESET, 8);
    chk("sleep wake", SBW_RESET, mode);
    end_sim();
  end
endmodule
bind sbw_supervisor sbw_sup_monitor i_sbw_sup_monitor (.core_clk, .rst, .wd_cfg_write, .wd_cfg_standby,
  .window_select_bit, .period_select_bit0, .period_select_bit1, .watchdog_timing_reg_access, .supply_good,
  .reset_out_n, .irq_out_n, .spi_accept, .safe_mode, .window_mode, .wd_period, .mode);
`default_nettype wire
